// File: hw/lbus_lanes.sv
// byte lane encoding for the high-byte enable and lowest address bit
`timescale 1ns/1ns
`default_nettype none
module lbus_lanes
  import lbus_pkg::*;
(
  input  wire logic     word,       // whole word transfer
  input  wire logic     odd,        // byte at odd address
  input  wire logic     inta,       // acknowledge cycle
  input  wire logic     inta_first, // first acknowledge cycle
  output logic          bhe_n,      // high-byte enable, active low
  output logic          a0          // lowest address bit
);

  // word 0/0, odd byte 0/1, even byte 1/0
  always_comb begin
    if (inta) begin
      bhe_n = !inta_first;
      a0    = 1'b0;
    end else if (word) begin
      bhe_n = 1'b0;
      a0    = 1'b0;
    end else begin
      bhe_n = !odd;
      a0    = odd;
    end
  end

endmodule
`default_nettype wire

// File: hw/lbus_pkg.sv
// constants and types for the multiplexed local bus processor port
//
// Behaviour
// - address on the shared lines in the address state, data in later states
// - lowest address bit low in the address state for a lower-byte transfer
// - shared lines float during interrupt acknowledge and hold
// - memory cycles show the four top address bits in the address state
// - I/O cycles hold the four upper lines low in the address state
// - upper lines carry status in the second, third, wait and fourth states
// - interrupt-enable status line follows the enable flag in second, third, wait and fourth states
// - segment code on two status lines, top status line always zero
// - upper address/status lines float during hold
// - high-byte enable low in the address state when the upper byte moves
// - high-byte enable and lowest address bit encode word, odd, even, none; the code never drives the none pair (1/1)
// - high-byte status driven in second, third and fourth states
// - high-byte enable/status pin floats during hold
// - high-byte enable low in the address state of the first acknowledge
// - read strobe marks a read, memory or I/O per its status line
// - read strobe low in second, third and wait states of every read
// - read strobe stays high until the shared lines stop driving address
// - read strobe floats during hold
package lbus_pkg;

  // ---------------------------------------------------------------
  // cycle kinds and segment codes
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    KIND_READ,
    KIND_WRITE,
    KIND_INTA
  } cycle_kind_t;

  localparam logic [1:0] SEG_ALT_DATA = 2'h0;
  localparam logic [1:0] SEG_STACK    = 2'h1;
  localparam logic [1:0] SEG_CODE     = 2'h2;
  localparam logic [1:0] SEG_DATA     = 2'h3;

  // ---------------------------------------------------------------
  // field positions on the upper lines and fixed pin values
  // ---------------------------------------------------------------
  localparam int          UP_TOP      = 3;
  localparam int          UP_IE       = 2;
  localparam logic        TOP_STATUS  = 1'b0;
  localparam logic [3:0]  IO_UPPER    = 4'h0;
  localparam logic [15:0] AD_RESET    = 16'h0000;
  localparam logic [3:0]  UP_RESET    = 4'h0;
  localparam logic        STROBE_IDLE = 1'b1;
  localparam logic        MIO_MEMORY  = 1'b1;
  localparam logic        MIO_IO      = 1'b0;

  // ---------------------------------------------------------------
  // one request from the core side
  // ---------------------------------------------------------------
  typedef struct packed {
    cycle_kind_t kind;        // read, write or acknowledge
    logic        is_io;       // i/o space instead of memory
    logic        word;        // whole word instead of one byte
    logic        inta_first;  // first of the two acknowledge cycles
    logic [1:0]  seg;         // segment code shown as status
    logic [19:0] addr;        // full address
    logic [15:0] wdata;       // write data
  } bus_req_t;

endpackage

// File: hw/lbus_port.sv
// processor side of the time-multiplexed local bus
`timescale 1ns/1ns
`default_nettype none
module lbus_port
  import lbus_pkg::*;
(
  input  wire logic        clk_sys,      // 25 MHz system clock
  input  wire logic        rst_b,        // async reset, active low
  // core side
  input  wire bus_req_t    req,          // request fields
  input  wire logic        req_valid,    // request present
  output var  logic        req_ready,    // port idle, takes request
  input  wire logic        ie_flag,      // interrupt enable flag
  output var  logic        done,         // one-cycle end of cycle
  output var  logic [15:0] rdata,        // read or vector data
  output var  logic        hold_ack,     // bus granted away
  // pins
  input  wire logic [15:0] ad_in,        // shared_addr_data_lines in
  output var  logic [15:0] ad_out,       // shared_addr_data_lines out
  output var  logic        ad_oe,        // shared lines driven
  output var  logic [3:0]  up_out,       // top, int_flag, seg high, seg low
  output var  logic        up_oe,        // upper lines driven
  output var  logic        high_byte_enable_status, // enable in T1, status later
  output var  logic        hbe_oe,       // high-byte pin driven
  output var  logic        rd_n,         // read strobe, active low
  output var  logic        rd_oe,        // read strobe driven
  output var  logic        memory_io_status_line, // high memory, low i/o
  output var  logic        mio_oe,       // memory/io line driven
  input  wire logic        ready_pin,    // ready from addressed device
  input  wire logic        hold_pin      // hold request from another master
);

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_T1,
    ST_T2,
    ST_T3,
    ST_TW,
    ST_T4,
    ST_HOLD
  } state_t;

  state_t      state;
  state_t      next_state;
  bus_req_t    cur;
  bus_req_t    src;
  logic        ready_s;
  logic        hold_s;
  logic [15:0] ad_s;
  logic        take;
  logic        lane_bhe_n;
  logic        lane_a0;
  logic        src_inta;
  logic        src_read;
  logic        in_status;

  lbus_sync #(.W(1)) u_ready (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .d       (ready_pin),
    .q       (ready_s)
  );

  lbus_sync #(.W(1)) u_hold (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .d       (hold_pin),
    .q       (hold_s)
  );

  // data pins pass two flops, so the value taken in T4 was on the pins two cycles before T4
  lbus_sync #(.W(16)) u_data (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .d       (ad_in),
    .q       (ad_s)
  );

  // ---------------------------------------------------------------
  // cycle sequencing
  // ---------------------------------------------------------------
  assign take     = req_valid && req_ready;
  assign src      = (state == ST_IDLE) ? req : cur;
  assign src_inta = (src.kind == KIND_INTA);
  assign src_read = (src.kind == KIND_READ);

  lbus_lanes u_lanes (
    .word       (src.word),
    .odd        (src.addr[0]),
    .inta       (src_inta),
    .inta_first (src.inta_first),
    .bhe_n      (lane_bhe_n),
    .a0         (lane_a0)
  );

  // a taken request beats a hold arriving in the same cycle
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (take) begin
          next_state = ST_T1;
        end else if (hold_s) begin
          next_state = ST_HOLD;
        end
      end
      ST_T1:   next_state = ST_T2;
      ST_T2:   next_state = ST_T3;
      ST_T3, ST_TW: begin
        next_state = ready_s ? ST_T4 : ST_TW;
      end
      ST_T4:   next_state = ST_IDLE;
      ST_HOLD: begin
        if (!hold_s) begin
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  assign in_status = (next_state == ST_T2) || (next_state == ST_T3) ||
                     (next_state == ST_TW) || (next_state == ST_T4);

  // state register
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // request latch, held for the whole cycle
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cur <= '0;
    end else if (take) begin
      cur <= req;
    end
  end

  // core handshake, registered so it is clean at the port
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      req_ready <= 1'b0;
      hold_ack  <= 1'b0;
      done      <= 1'b0;
    end else begin
      req_ready <= (next_state == ST_IDLE);
      hold_ack  <= (next_state == ST_HOLD);
      done      <= (state == ST_T4);
    end
  end

  // read data: synchronised value seen during T4
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rdata <= AD_RESET;
    end else if (state == ST_T4 && cur.kind != KIND_WRITE) begin
      rdata <= ad_s;
    end
  end

  // ---------------------------------------------------------------
  // shared address/data lines
  // ---------------------------------------------------------------
  // address in T1, write data after; read and acknowledge float
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ad_out <= AD_RESET;
      ad_oe  <= 1'b0;
    end else if (next_state == ST_T1) begin
      ad_out <= {src.addr[15:1], lane_a0};
      ad_oe  <= !src_inta;
    end else if (in_status && src.kind == KIND_WRITE) begin
      ad_out <= src.wdata;
      ad_oe  <= 1'b1;
    end else begin
      ad_out <= AD_RESET;
      ad_oe  <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // upper address/status lines
  // ---------------------------------------------------------------
  // address bits or zero in T1, status after; enable flag in each status clock, zero when idle
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      up_out <= UP_RESET;
      up_oe  <= 1'b0;
    end else if (next_state == ST_T1) begin
      up_out <= src.is_io ? IO_UPPER : src.addr[19:16];
      up_oe  <= 1'b1;
    end else if (in_status) begin
      up_out <= {TOP_STATUS, ie_flag, src.seg};
      up_oe  <= 1'b1;
    end else begin
      up_out <= UP_RESET;
      up_oe  <= (next_state != ST_HOLD);
    end
  end

  // ---------------------------------------------------------------
  // high-byte enable/status pin
  // ---------------------------------------------------------------
  // status keeps the enable value so a late latch still sees it
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      high_byte_enable_status <= STROBE_IDLE;
      hbe_oe                  <= 1'b0;
    end else if (next_state == ST_T1) begin
      high_byte_enable_status <= lane_bhe_n;
      hbe_oe                  <= 1'b1;
    end else if (in_status) begin
      high_byte_enable_status <= high_byte_enable_status;
      hbe_oe                  <= 1'b1;
    end else begin
      high_byte_enable_status <= STROBE_IDLE;
      hbe_oe                  <= (next_state != ST_HOLD);
    end
  end

  // ---------------------------------------------------------------
  // read strobe and memory/io line
  // ---------------------------------------------------------------
  // strobe falls on the same edge that floats the address
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rd_n  <= STROBE_IDLE;
      rd_oe <= 1'b0;
    end else begin
      rd_n  <= !(src_read && (next_state == ST_T2 || next_state == ST_T3 ||
                               next_state == ST_TW));
      rd_oe <= (next_state != ST_HOLD);
    end
  end

  // memory or i/o for the cycle under way
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      memory_io_status_line <= MIO_MEMORY;
      mio_oe                <= 1'b0;
    end else begin
      if (next_state == ST_T1 || in_status) begin
        memory_io_status_line <= src.is_io ? MIO_IO : MIO_MEMORY;
      end else begin
        memory_io_status_line <= MIO_MEMORY;
      end
      mio_oe <= (next_state != ST_HOLD);
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_addr_t1;
    @(posedge clk_sys) disable iff (!rst_b)
    (state == ST_T1 && cur.kind != KIND_INTA) |->
      ad_oe && ad_out[15:1] == cur.addr[15:1];
  endproperty
  a_addr_t1: assert property (p_addr_t1) else $error("address missing in T1");

  property p_low_byte;
    @(posedge clk_sys) disable iff (!rst_b)
    (state == ST_T1 && cur.kind != KIND_INTA && !cur.word && !cur.addr[0])
      |-> !ad_out[0] && high_byte_enable_status;
  endproperty
  a_low_byte: assert property (p_low_byte) else $error("even byte lanes wrong");

  property p_float_inta;
    @(posedge clk_sys) disable iff (!rst_b)
    (state != ST_IDLE && state != ST_HOLD && cur.kind == KIND_INTA) |-> !ad_oe;
  endproperty
  a_float_inta: assert property (p_float_inta) else $error("shared lines driven in ack");

  property p_upper_t1;
    @(posedge clk_sys) disable iff (!rst_b)
    (state == ST_T1) |->
      up_oe && up_out == (cur.is_io ? IO_UPPER : cur.addr[19:16]);
  endproperty
  a_upper_t1: assert property (p_upper_t1) else $error("upper lines wrong in T1");

  property p_status;
    @(posedge clk_sys) disable iff (!rst_b)
    (state inside {ST_T2, ST_T3, ST_TW, ST_T4}) |->
      up_out[UP_TOP] == TOP_STATUS && up_out[1:0] == cur.seg &&
      up_out[UP_IE] == $past(ie_flag);
  endproperty
  a_status: assert property (p_status) else $error("status lines wrong");

  property p_hold_float;
    @(posedge clk_sys) disable iff (!rst_b)
    (state == ST_HOLD) |-> !ad_oe && !up_oe && !hbe_oe && !rd_oe && hold_ack;
  endproperty
  a_hold_float: assert property (p_hold_float) else $error("pin driven in hold");

  property p_first_ack;
    @(posedge clk_sys) disable iff (!rst_b)
    (state == ST_T1 && cur.kind == KIND_INTA && cur.inta_first) |->
      !high_byte_enable_status ##1 (hbe_oe && !high_byte_enable_status);
  endproperty
  a_first_ack: assert property (p_first_ack) else $error("first ack enable high");

  property p_read_low;
    @(posedge clk_sys) disable iff (!rst_b)
    (state inside {ST_T2, ST_T3, ST_TW} && cur.kind == KIND_READ) |-> !rd_n;
  endproperty
  a_read_low: assert property (p_read_low) else $error("read strobe not low");

  property p_read_float;
    @(posedge clk_sys) disable iff (!rst_b)
    !rd_n |-> !ad_oe && state != ST_T1;
  endproperty
  a_read_float: assert property (p_read_float) else $error("read while address driven");

  property p_sequence;
    @(posedge clk_sys) disable iff (!rst_b)
    (state == ST_T1) |=> (state == ST_T2) ##1 (state == ST_T3);
  endproperty
  a_sequence: assert property (p_sequence) else $error("T1 T2 T3 order broken");

  // ready as seen in the waiting cycle decides, not its value one cycle on
  property p_wait;
    @(posedge clk_sys) disable iff (!rst_b)
    (state inside {ST_T3, ST_TW}) |=> (state inside {ST_T4, ST_TW}) &&
      ((state == ST_T4) == $past(ready_s));
  endproperty
  a_wait: assert property (p_wait) else $error("wait state handling wrong");

  // status on the high-byte pin repeats the enable through the cycle
  property p_hbe_status;
    @(posedge clk_sys) disable iff (!rst_b)
    (state inside {ST_T2, ST_T3, ST_TW, ST_T4}) |->
      hbe_oe && (high_byte_enable_status == $past(high_byte_enable_status));
  endproperty
  a_hbe_status: assert property (p_hbe_status) else $error("high-byte status lost");

  // memory/io line names the space of the cycle under way
  property p_mio;
    @(posedge clk_sys) disable iff (!rst_b)
    (state inside {ST_T1, ST_T2, ST_T3, ST_TW, ST_T4}) |->
      mio_oe && (memory_io_status_line == (cur.is_io ? MIO_IO : MIO_MEMORY));
  endproperty
  a_mio: assert property (p_mio) else $error("memory/io line wrong");

endmodule
`default_nettype wire

// File: hw/lbus_sync.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/1ns
`default_nettype none
module lbus_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_sys, // system clock
  input  wire logic         rst_b,   // async reset, active low
  input  wire logic [W-1:0] d,       // asynchronous pin level
  output var  logic [W-1:0] q        // level safe to use
);

  logic [W-1:0] meta;

  // first flop feeds only the second
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule
`default_nettype wire

// File: testbench/lbus_mem_model.sv
// memory and i/o device model on the far side of the local bus
`timescale 1ns/1ns
`default_nettype none
module lbus_mem_model #(
  parameter logic [15:0] VEC = 16'h0048  // acknowledge vector, arbitrary value
) (
  input  wire logic        clk_sys,   // system clock
  input  wire logic        rst_b,     // async reset, active low
  input  wire logic        take,      // request taken at this edge
  input  wire logic [3:0]  waits,     // wait states to ask for
  input  wire logic [15:0] ad_out,    // shared lines from the port
  input  wire logic        ad_oe,     // port drives the shared lines
  input  wire logic        hbe,       // high-byte enable pin
  output var  logic [15:0] ad_in,     // resolved shared line level
  output var  logic        ready_pin, // ready back to the port
  output var  logic [15:0] wseen      // bytes latched by writes
);
  logic [4:0]  cnt;
  logic [15:0] last;
  logic [15:0] t1_ad;
  logic        t1_oe;
  logic        t1_hbe;
  logic [15:0] data;
  logic        win;

  // ---------------------------------------------------------------
  // cycle position
  // ---------------------------------------------------------------
  // counts edges since the take; saturates so idle time never wraps
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) cnt <= 5'h1f;
    else if (take) cnt <= 5'h00;
    else if (cnt != 5'h1f) cnt <= cnt + 5'h01;
  end

  // ready held off for the asked number of waits
  assign ready_pin = ({1'b0, waits} <= cnt);

  // ---------------------------------------------------------------
  // address latch and lane select
  // ---------------------------------------------------------------
  // address and lane enables latched at the end of the address state
  always_ff @(posedge clk_sys) begin
    if (cnt == 5'h00) begin
      t1_ad  <= ad_out;
      t1_oe  <= ad_oe;
      t1_hbe <= hbe;
    end
  end

  // byte-wide halves selected by their own enable only
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) wseen <= 16'h0000;
    else if (ad_oe && cnt >= 5'h01 && cnt <= {1'b0, waits} + 5'h03) begin
      if (!t1_hbe) wseen[15:8] <= ad_out[15:8];
      if (!t1_ad[0]) wseen[7:0] <= ad_out[7:0];
    end
  end

  // ---------------------------------------------------------------
  // line resolution
  // ---------------------------------------------------------------
  // outside its window the line shows no stale value: it keeps toggling
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) last <= 16'h0000;
    else last <= ad_in;
  end

  assign data  = t1_oe ? (t1_ad ^ 16'h5a5a) : VEC;
  assign win   = cnt >= 5'h01 && cnt <= {1'b0, waits} + 5'h04;
  assign ad_in = ad_oe ? ad_out : (win ? data : ~last);
endmodule
`default_nettype wire

// File: testbench/lbus_port_tb_top.sv
// self-checking testbench for the local bus processor port
`timescale 1ns/1ns
`default_nettype none
module lbus_port_tb_top
  import lbus_pkg::*;
;
  logic        clk_sys;
  logic        rst_b;
  bus_req_t    req;
  logic        req_valid;
  logic        req_ready;
  logic        ie_flag;
  logic        done;
  logic [15:0] rdata;
  logic        hold_ack;
  logic [15:0] ad_in;
  logic [15:0] ad_out;
  logic        ad_oe;
  logic [3:0]  up_out;
  logic        up_oe;
  logic        hbe;
  logic        hbe_oe;
  logic        rd_n;
  logic        rd_oe;
  logic        mio;
  logic        mio_oe;
  logic        ready_pin;
  logic        hold_pin;
  logic [3:0]  waits;
  logic [15:0] wseen;
  int          errors;
  int          checks;
  int          n;

  lbus_port i_lbus_port (
    .clk_sys(clk_sys), .rst_b(rst_b), .req(req), .req_valid(req_valid),
    .req_ready(req_ready), .ie_flag(ie_flag), .done(done), .rdata(rdata),
    .hold_ack(hold_ack), .ad_in(ad_in), .ad_out(ad_out), .ad_oe(ad_oe),
    .up_out(up_out), .up_oe(up_oe), .high_byte_enable_status(hbe), .hbe_oe(hbe_oe),
    .rd_n(rd_n), .rd_oe(rd_oe), .memory_io_status_line(mio), .mio_oe(mio_oe),
    .ready_pin(ready_pin), .hold_pin(hold_pin)
  );

  lbus_mem_model i_lbus_mem_model (
    .clk_sys(clk_sys), .rst_b(rst_b), .take(req_valid && req_ready), .waits(waits),
    .ad_out(ad_out), .ad_oe(ad_oe), .hbe(hbe), .ad_in(ad_in),
    .ready_pin(ready_pin), .wseen(wseen)
  );

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic close_out();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [19:0] seen, input logic [19:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one full bus cycle, checked state by state
  task automatic run(input string name, input bus_req_t r, input logic [3:0] w,
                     input logic ie);
    logic        a0;
    logic        bh;
    logic [15:0] t1;
    logic [15:0] m;
    a0 = r.word ? 1'b0 : r.addr[0];
    bh = (r.kind == KIND_INTA) ? !r.inta_first : (!r.word && !r.addr[0]);
    t1 = {r.addr[15:1], a0};
    m  = {{8{!bh}}, {8{!a0}}};
    n  = 0;
    while (req_ready !== 1'b1 && n < 50) begin
      @(negedge clk_sys);
      n++;
    end
    @(posedge clk_sys);
    req       <= r;
    req_valid <= 1'b1;
    waits     <= w;
    ie_flag   <= ie;
    @(posedge clk_sys);
    req_valid <= 1'b0;
    @(negedge clk_sys);
    if (r.kind == KIND_INTA) check("ad_oe t1", ad_oe, 0);
    else begin
      check("ad_oe t1", ad_oe, 1);
      check("addr t1", ad_out, t1);
      check("upper t1", up_out, r.is_io ? IO_UPPER : r.addr[19:16]);
      check("mio t1", mio, r.is_io ? MIO_IO : MIO_MEMORY);
    end
    check("hbe t1", hbe, bh);
    check("oe t1", {up_oe, hbe_oe, rd_oe, mio_oe}, 4'hf);
    check("rd_n t1", rd_n, 1);
    @(negedge clk_sys);
    check("ad_oe t2", ad_oe, r.kind == KIND_WRITE);
    if (r.kind != KIND_INTA) check("status t2", up_out, {TOP_STATUS, ie, r.seg});
    check("hbe status", hbe, bh);
    n = 2;
    while (done !== 1'b1 && n < 30) begin
      check("rd_n", rd_n, (r.kind == KIND_READ && n <= 3 + w) ? 1'b0 : 1'b1);
      @(negedge clk_sys);
      n++;
    end
    check("done time", 20'(n), 20'(5 + w));
    if (r.kind == KIND_WRITE) check("write data", wseen & m, r.wdata & m);
    else check("read data", rdata, r.kind == KIND_INTA ? 16'h0048 : t1 ^ 16'h5a5a);
    $display("test %s done", name);
  endtask

  // ---------------------------------------------------------------
  // clock, reset, watchdog
  // ---------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  // the whole run is well under a thousand cycles
  initial begin
    repeat (3000) @(posedge clk_sys);
    errors++;
    close_out();
  end

  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    rst_b     = 1'b0;
    req       = '0;
    req_valid = 1'b0;
    ie_flag   = 1'b0;
    hold_pin  = 1'b0;
    waits     = 4'h0;
    errors    = 0;
    checks    = 0;
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'b1;
    run("word read", '{KIND_READ, 1'b0, 1'b1, 1'b0, SEG_DATA, 20'ha_1234, 16'h0000}, 4'h0, 1'b1);
    run("odd write", '{KIND_WRITE, 1'b0, 1'b0, 1'b0, SEG_STACK, 20'h5_0011, 16'hbeef}, 4'h2,
        1'b0);
    run("even io read", '{KIND_READ, 1'b1, 1'b0, 1'b0, SEG_ALT_DATA, 20'h0_0f20, 16'h0000}, 4'h1,
        1'b1);
    run("io word write", '{KIND_WRITE, 1'b1, 1'b1, 1'b0, SEG_CODE, 20'h0_0c40, 16'h1357}, 4'h0,
        1'b0);
    run("first ack", '{KIND_INTA, 1'b0, 1'b1, 1'b1, SEG_CODE, 20'h0_0000, 16'h0000}, 4'h1, 1'b1);
    run("second ack", '{KIND_INTA, 1'b0, 1'b1, 1'b0, SEG_CODE, 20'h0_0000, 16'h0000}, 4'h0, 1'b0);
    // hold: every driven pin must float while the bus is granted away
    @(posedge clk_sys);
    hold_pin <= 1'b1;
    n = 0;
    while (hold_ack !== 1'b1 && n < 20) begin
      @(negedge clk_sys);
      n++;
    end
    check("hold ack", hold_ack, 1);
    check("float", {ad_oe, up_oe, hbe_oe, rd_oe, mio_oe}, 5'h00);
    check("ready in hold", req_ready, 0);
    @(posedge clk_sys);
    hold_pin <= 1'b0;
    $display("test hold done");
    run("read after hold", '{KIND_READ, 1'b0, 1'b0, 1'b0, SEG_DATA, 20'hf_fff1, 16'h0000}, 4'h3,
        1'b1);
    close_out();
  end
endmodule
`default_nettype wire
